// *** hdl/vid_capture_pkg.sv ***
package vid_capture_pkg;

	// Register offsets on the byte-wide register port.
	localparam logic [7:0] CPU_ONE_VOLTAGE_CODE_OFFSET = 8'h6c;
	localparam logic [7:0] CPU_TWO_VOLTAGE_CODE_OFFSET = 8'h6d;
	localparam logic [7:0] VID_MODE_CTRL_OFFSET        = 8'hbd;

	// Reset values of the registers.
	localparam logic [7:0] VOLTAGE_CODE_RESET = 8'h00;
	localparam logic [1:0] VID_MODE_RESET     = 2'h0;

	// Position of the mode field inside the mode control register.
	localparam int VID_MODE_LSB = 0;
	localparam int VID_MODE_MSB = 1;

	// Encodings of the identification mode field.
	localparam logic [1:0] MODE_SIX_BIT_LEGACY     = 2'h0;
	localparam logic [1:0] MODE_SEVEN_BIT_EXTENDED = 2'h1;
	localparam logic [1:0] MODE_NEWER_REGULATOR_1  = 2'h2;
	localparam logic [1:0] MODE_NEWER_REGULATOR_2  = 2'h3;

	// Width of one processor's identification pin group.
	localparam int VID_WIDTH = 8;

	// Stability time and the clock period, in nanoseconds.
	localparam int VID_STABLE_NS = 600;
	localparam int CLK_PERIOD_NS = 40;

	// Least stable time rounds up to whole cycles, never less than one.
	localparam int STABLE_CYCLES_RAW = (VID_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STABLE_CYCLES     = (STABLE_CYCLES_RAW < 1) ? 1 : STABLE_CYCLES_RAW;

	// Width of the stability counter and its terminal value.
	localparam int STABLE_CNT_W = 5;
	localparam logic [STABLE_CNT_W-1:0] STABLE_CNT_DONE = STABLE_CNT_W'(STABLE_CYCLES);

endpackage

// *** hdl/vid_filter_if.sv ***
`timescale 1ns/1ns
`default_nettype none

// Carries one processor's raw identification pins into a stability filter
// and brings the qualified code back out.
interface vid_filter_if;
	import vid_capture_pkg::*;

	logic [VID_WIDTH-1:0] pins; // Raw pins, asynchronous to the clock.
	logic [VID_WIDTH-1:0] code; // Last code that stayed stable long enough.

	// The filter takes the pins and drives the qualified code.
	modport filt (
		input  pins,
		output code
	);

	// The user drives the pins and reads the qualified code.
	modport user (
		output pins,
		input  code
	);
endinterface

`default_nettype wire

// *** hdl/vid_stability_filter.sv ***
`timescale 1ns/1ns
`default_nettype none

// Synchronises one processor's identification pins and passes a new code on
// only after every pin has held still for the full stability time.
module vid_stability_filter (
	input  wire logic      clk_sys,
	input  wire logic      rstn,
	input  wire logic      clk_en,
	vid_filter_if.filt     vid
);
	import vid_capture_pkg::*;

	logic [VID_WIDTH-1:0]    meta_r;     // First synchroniser stage.
	logic [VID_WIDTH-1:0]    sync_r;     // Second synchroniser stage.
	logic [VID_WIDTH-1:0]    held_r;     // Value being timed for stability.
	logic [STABLE_CNT_W-1:0] cnt_r;      // Cycles since the last change.
	logic [STABLE_CNT_W-1:0] cnt_nxt;    // Next counter value.
	logic [VID_WIDTH-1:0]    code_r;     // Qualified code.
	logic                    changed;    // Any pin differs from the held value.
	logic                    cnt_done;   // Held value has been stable long enough.

	// A change on any pin is a difference from the held value.
	assign changed  = (sync_r != held_r);
	assign cnt_done = (cnt_r == STABLE_CNT_DONE);

	// The counter restarts on a change and saturates once stable.
	assign cnt_nxt = changed  ? '0 :
	                 cnt_done ? cnt_r :
	                 STABLE_CNT_W'(cnt_r + 1'b1); // R11

	// Two flip-flops keep metastability away from the compare logic.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else if (clk_en) begin
			meta_r <= vid.pins;
			sync_r <= meta_r;
		end
	end

	// Track the latest value and time how long it has held.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			held_r <= '0;
			cnt_r  <= '0;
		end else if (clk_en) begin
			held_r <= sync_r; // R11
			cnt_r  <= cnt_nxt; // R11
		end
	end

	// Only a value that stayed put for the whole time is passed on.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			code_r <= VOLTAGE_CODE_RESET;
		end else if (clk_en && cnt_done && !changed) begin
			code_r <= held_r; // R4 R5
		end
	end

	assign vid.code = code_r;

endmodule

`default_nettype wire

// *** hdl/dual_cpu_vid_capture.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// (R1) CPU one seven-bit mode: pins 6:0, bit7 zero.
// (R2) CPU one newer mode one: pins 6:0.
// (R3) CPU one newer mode two: pins 7:1, bit0 zero.
// (R4) CPU one byte updates after 600 ns stable.
// (R5) CPU two byte updates after 600 ns stable.
// (R6) CPU two packing follows mode field; resets 00h.
// (R7) CPU two legacy mode: pins 5:0, top zero.
// (R8) CPU two seven-bit mode: pins 6:0, bit7 zero.
// (R9) CPU two newer mode two: pins 7:1, bit0 zero.
// (R10) CPU one legacy mode: pins 5:0, top zero.
// (R11) Stability counts clocks, restarts on any change.

// Captures both processors' identification codes, qualifies them for
// stability and presents them as read-only bytes packed per the mode field.
module dual_cpu_vid_capture (
	input  wire logic                           clk_sys,
	input  wire logic                           rstn,
	input  wire logic                           clk_en,
	input  wire logic [vid_capture_pkg::VID_WIDTH-1:0] cpu_one_vid_pins,
	input  wire logic [vid_capture_pkg::VID_WIDTH-1:0] cpu_two_vid_pins,
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [7:0]                     reg_rdata
);
	import vid_capture_pkg::*;

	// One filter link per processor.
	vid_filter_if cpu_one_link ();
	vid_filter_if cpu_two_link ();

	logic [1:0] vid_mode_r;          // Identification mode field.
	logic [7:0] cpu_one_code_r;      // Packed status byte of processor one.
	logic [7:0] cpu_two_code_r;      // Packed status byte of processor two.
	logic [7:0] rdata_r;             // Read data, valid the cycle after a read.

	logic [7:0] one_code;            // Qualified code of processor one.
	logic [7:0] two_code;            // Qualified code of processor two.
	logic [7:0] one_legacy;          // Processor one in six-bit packing.
	logic [7:0] one_seven;           // Processor one in seven-bit packing.
	logic [7:0] one_upper;           // Processor one in pins 7:1 packing.
	logic [7:0] two_legacy;          // Processor two in six-bit packing.
	logic [7:0] two_seven;           // Processor two in seven-bit packing.
	logic [7:0] two_upper;           // Processor two in pins 7:1 packing.
	logic [7:0] cpu_one_code_nxt;    // Next status byte of processor one.
	logic [7:0] cpu_two_code_nxt;    // Next status byte of processor two.
	logic [7:0] rdata_nxt;           // Next read data.
	logic       sel_one;             // Address hits processor one's byte.
	logic       sel_two;             // Address hits processor two's byte.
	logic       sel_mode;            // Address hits the mode register.
	logic       mode_wr;             // Write to the mode register.

	// The raw pins enter the filters; they synchronise internally.
	assign cpu_one_link.pins = cpu_one_vid_pins;
	assign cpu_two_link.pins = cpu_two_vid_pins;

	// Processor one's stability filter.
	vid_stability_filter u_cpu_one_filter (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.clk_en  (clk_en),
		.vid     (cpu_one_link.filt)
	); // R4

	// Processor two's stability filter.
	vid_stability_filter u_cpu_two_filter (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.clk_en  (clk_en),
		.vid     (cpu_two_link.filt)
	); // R5

	assign one_code = cpu_one_link.code;
	assign two_code = cpu_two_link.code;

	// Processor one packings; unused bits read as zero.
	assign one_legacy = {2'h0, one_code[5:0]}; // R10
	assign one_seven  = {1'b0, one_code[6:0]}; // R1 R2
	assign one_upper  = {one_code[7:1], 1'b0}; // R3

	// Processor two packings; unused bits read as zero.
	assign two_legacy = {2'h0, two_code[5:0]}; // R7
	assign two_seven  = {1'b0, two_code[6:0]}; // R8
	assign two_upper  = {two_code[7:1], 1'b0}; // R9

	// Processor one's byte selected by the mode field.
	always_comb begin
		unique case (vid_mode_r)
			MODE_SIX_BIT_LEGACY: begin
				cpu_one_code_nxt = one_legacy; // R10
			end
			MODE_SEVEN_BIT_EXTENDED: begin
				cpu_one_code_nxt = one_seven; // R1
			end
			MODE_NEWER_REGULATOR_1: begin
				cpu_one_code_nxt = one_seven; // R2
			end
			MODE_NEWER_REGULATOR_2: begin
				cpu_one_code_nxt = one_upper; // R3
			end
		endcase
	end

	// Processor two's byte selected by the mode field.
	always_comb begin
		unique case (vid_mode_r)
			MODE_SIX_BIT_LEGACY: begin
				cpu_two_code_nxt = two_legacy; // R7
			end
			MODE_SEVEN_BIT_EXTENDED: begin
				cpu_two_code_nxt = two_seven; // R8
			end
			MODE_NEWER_REGULATOR_1: begin
				cpu_two_code_nxt = two_seven; // R6
			end
			MODE_NEWER_REGULATOR_2: begin
				cpu_two_code_nxt = two_upper; // R9
			end
		endcase
	end

	// Address decode for the register port.
	assign sel_one  = (reg_addr == CPU_ONE_VOLTAGE_CODE_OFFSET);
	assign sel_two  = (reg_addr == CPU_TWO_VOLTAGE_CODE_OFFSET);
	assign sel_mode = (reg_addr == VID_MODE_CTRL_OFFSET);
	assign mode_wr  = reg_wr && sel_mode;

	// Read mux; unmapped addresses and reserved bits read as zero.
	assign rdata_nxt = !reg_rd  ? 8'h00 :
	                   sel_one  ? cpu_one_code_r :
	                   sel_two  ? cpu_two_code_r :
	                   sel_mode ? {6'h00, vid_mode_r} :
	                   8'h00;

	// Mode field; the only software-writable state here.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vid_mode_r <= VID_MODE_RESET;
		end else if (clk_en && mode_wr) begin
			vid_mode_r <= reg_wdata[VID_MODE_MSB:VID_MODE_LSB]; // R6
		end
	end

	// Status bytes follow the qualified codes in the current packing.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cpu_one_code_r <= VOLTAGE_CODE_RESET;
			cpu_two_code_r <= VOLTAGE_CODE_RESET; // R6
		end else if (clk_en) begin
			cpu_one_code_r <= cpu_one_code_nxt;
			cpu_two_code_r <= cpu_two_code_nxt;
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 8'h00;
		end else if (clk_en) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

endmodule

`default_nettype wire

// *** bench/vid_pin_source.sv ***
`timescale 1ns/1ns
`default_nettype none

// Stands in for both processors' identification outputs.
module vid_pin_source (
	input  wire logic      clk_sys,
	output var logic [7:0] pins_one,
	output var logic [7:0] pins_two
);
	// Pins start at zero, the same as the cleared code after reset.
	initial begin
		pins_one = 8'h00;
		pins_two = 8'h00;
	end

	// Moves both pin groups just after a clock edge, as a processor would.
	task automatic set_codes(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk_sys);
		pins_one <= a;
		pins_two <= b;
	endtask
endmodule

`default_nettype wire

// *** bench/vid_capture_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

// Checks read data of the capture block against its pins and mode.
module vid_capture_sva (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       clk_en,
	input wire logic [7:0] cpu_one_vid_pins,
	input wire logic [7:0] cpu_two_vid_pins,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata
);
	logic [1:0] mode_r, mode_d; // Mode field and its copy one cycle late.
	logic [4:0] run1_r, run2_r; // Cycles each pin group has held still.
	logic [7:0] last1_r, last2_r; // Pins seen at the previous edge.
	logic       rd_en, same; // A taken read, and a mode that has settled.
	assign rd_en = clk_en && reg_rd;
	assign same = mode_r == mode_d;

	// Packs a pin group as the mode asks.
	function automatic logic [7:0] pk(input logic [1:0] m, input logic [7:0] v);
		pk = (m == 2'h0) ? {2'h0, v[5:0]} : (m == 2'h3) ? {v[7:1], 1'h0} : {1'h0, v[6:0]};
	endfunction

	// Tracks the mode and restarts each run count on any pin change.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_r <= 2'h0;
			mode_d <= 2'h0;
			run1_r <= 5'h0;
			run2_r <= 5'h0;
			last1_r <= 8'h00;
			last2_r <= 8'h00;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == 8'hbd) begin
				mode_r <= reg_wdata[1:0];
			end
			mode_d <= mode_r;
			last1_r <= cpu_one_vid_pins;
			last2_r <= cpu_two_vid_pins;
			run1_r <= (cpu_one_vid_pins != last1_r) ? 5'h0 : run1_r + {4'h0, run1_r != 5'h1f};
			run2_r <= (cpu_two_vid_pins != last2_r) ? 5'h0 : run2_r + {4'h0, run2_r != 5'h1f};
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_idle_rdata_zero: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not cleared after idle cycle");
	a_unmapped_zero: assert property (rd_en && !(reg_addr inside {8'h6c, 8'h6d, 8'hbd})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_mode_readback: assert property (rd_en && reg_addr == 8'hbd
		|=> reg_rdata == {6'h00, $past(mode_r)}) else $error("mode readback wrong");
	a_one_legacy_top: assert property (rd_en && reg_addr == 8'h6c && same && mode_r == 2'h0
		|=> reg_rdata[7:6] == 2'h0) else $error("cpu one legacy top bits set");
	a_two_legacy_top: assert property (rd_en && reg_addr == 8'h6d && same && mode_r == 2'h0
		|=> reg_rdata[7:6] == 2'h0) else $error("cpu two legacy top bits set");
	a_bit7_zero: assert property (rd_en && reg_addr[7:1] == 7'h36 && same && ^mode_r
		|=> !reg_rdata[7]) else $error("seven bit mode top bit set");
	a_bit0_zero: assert property (rd_en && reg_addr[7:1] == 7'h36 && same && &mode_r
		|=> !reg_rdata[0]) else $error("newer mode two bit zero set");
	a_one_settled: assert property (rd_en && reg_addr == 8'h6c && same && run1_r >= 5'h14
		|=> reg_rdata == pk($past(mode_r), $past(last1_r))) else $error("cpu one code stale");
	a_two_settled: assert property (rd_en && reg_addr == 8'h6d && same && run2_r >= 5'h14
		|=> reg_rdata == pk($past(mode_r), $past(last2_r))) else $error("cpu two code stale");

	c_mode_three: cover property (rd_en && reg_addr == 8'h6d && same && &mode_r);
	c_one_settled: cover property (rd_en && reg_addr == 8'h6c && run1_r >= 5'h14);
	c_restart: cover property ((run1_r > 5'h3 && run1_r < 5'h13) ##1 run1_r == 5'h0);
endmodule

bind dual_cpu_vid_capture vid_capture_sva vid_capture_sva_inst (.clk_sys, .rstn, .clk_en,
	.cpu_one_vid_pins, .cpu_two_vid_pins, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

// Drives the register port and both pin groups, and checks the bytes read.
module testbench;
	logic       clk_sys, rstn, reg_wr, reg_rd; // Clock, reset and strobes.
	logic       clk_en; // Clock enable, dropped once to test the freeze.
	logic [7:0] p1, p2, reg_addr, reg_wdata, reg_rdata; // Pins and bus.
	int         num_errors = 0; // Mismatches seen.
	int         compares = 0; // Comparisons made.

	// Free running 25 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	vid_pin_source vid_pin_source_inst (.clk_sys(clk_sys), .pins_one(p1), .pins_two(p2));
	dual_cpu_vid_capture dual_cpu_vid_capture_inst (.clk_sys(clk_sys), .rstn(rstn),
		.clk_en(clk_en), .cpu_one_vid_pins(p1), .cpu_two_vid_pins(p2), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// Packs a pin group as the mode asks.
	function automatic logic [7:0] pk(input logic [1:0] m, input logic [7:0] v);
		pk = (m == 2'h0) ? {2'h0, v[5:0]} : (m == 2'h3) ? {v[7:1], 1'h0} : {1'h0, v[6:0]};
	endfunction

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One cycle write strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// One cycle read strobe; the data stand only in the next cycle.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short well past the expected few hundred cycles.
	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end

	// Main sequence.
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_chk(8'h6d, 8'h00);
		wr(8'h6d, 8'hff);
		rd_chk(8'h6d, 8'h00);
		rd_chk(8'hbd, 8'h00);
		$display("test reset done");
		vid_pin_source_inst.set_codes(8'hd5, 8'h6b);
		repeat (25) @(posedge clk_sys);
		rd_chk(8'h6e, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(8'hbd, 8'(m));
			rd_chk(8'hbd, 8'(m));
			rd_chk(8'h6c, pk(2'(m), 8'hd5));
			rd_chk(8'h6d, pk(2'(m), 8'h6b));
		end
		$display("test modes done");
		vid_pin_source_inst.set_codes(8'h3c, 8'hc3);
		repeat (11) @(posedge clk_sys);
		vid_pin_source_inst.set_codes(8'h81, 8'h19);
		repeat (9) @(posedge clk_sys);
		rd_chk(8'h6c, 8'hd4);
		rd_chk(8'h6d, 8'h6a);
		repeat (20) @(posedge clk_sys);
		rd_chk(8'h6c, 8'h80);
		rd_chk(8'h6d, 8'h18);
		$display("test stability done");
		// With the enable low the filter is frozen, so new pins must not get through.
		@(posedge clk_sys);
		clk_en <= 1'b0;
		vid_pin_source_inst.set_codes(8'h42, 8'h24);
		repeat (25) @(posedge clk_sys);
		clk_en <= 1'b1;
		rd_chk(8'h6c, 8'h80);
		repeat (25) @(posedge clk_sys);
		rd_chk(8'h6c, 8'h42);
		rd_chk(8'h6d, 8'h24);
		$display("test enable done");
		print_verdict;
	end
endmodule

`default_nettype wire
